// >>> rtl/pie_defs.svh
`ifndef PIE_DEFS_SVH
`define PIE_DEFS_SVH

// Word width of the control, buffer and counter registers and of the processor accumulator.
`define PIE_W 12

// Control word fields, vector index = 11 - accumulator bit number.
`define PIE_EN_OVF     11
`define PIE_MODE_HI    10
`define PIE_MODE_LO    9
`define PIE_RATE_HI    8
`define PIE_RATE_LO    6
`define PIE_EXT_START  5
`define PIE_INHIBIT    4
`define PIE_IRQ_EN     3
`define PIE_TRIG4_EN   2
`define PIE_TRIG2_EN   1
`define PIE_TRIG1_EN   0

// Status word positions as they land in the accumulator.
`define PIE_ST_OVF     11
`define PIE_ST_EV4     2
`define PIE_ST_EV2     1
`define PIE_ST_EV1     0

// Reset values, and the all-ones count that marks an overflow.
`define PIE_CTRL_RST   12'h000
`define PIE_COUNT_RST  12'h000
`define PIE_BUF_RST    12'h000
`define PIE_ALL_ONES   12'hfff

// Time base: fastest rate in hertz and its period in clock cycles.
`define PIE_CLK_HZ       125000000
`define PIE_BASE_HZ      100000
`define PIE_BASE_CYC     (`PIE_CLK_HZ / `PIE_BASE_HZ)
`define PIE_BASE_CYC_W   11
`define PIE_DECADE       10
`define PIE_DECADE_W     4

`endif

// >>> rtl/pie_pkg.sv
package pie_pkg;

  // Low octal digit of a processor transfer command.
  typedef enum logic [2:0] {
    PIE_CMD_CLR_BITS  = 3'h0,
    PIE_CMD_SKIP      = 3'h1,
    PIE_CMD_SET_BITS  = 3'h2,
    PIE_CMD_PRESET    = 3'h3,
    PIE_CMD_RD_CTRL   = 3'h4,
    PIE_CMD_RD_STATUS = 3'h5,
    PIE_CMD_RD_BUF    = 3'h6,
    PIE_CMD_RD_COUNT  = 3'h7
  } pie_cmd_t;

  // Counting modes held in the mode field.
  typedef enum logic [1:0] {
    PIE_MODE_FREE    = 2'h0,
    PIE_MODE_RELOAD  = 2'h1,
    PIE_MODE_CAPTURE = 2'h2,
    PIE_MODE_CAP_CLR = 2'h3
  } pie_mode_t;

  // A transfer request from the processor.
  typedef struct packed {
    logic        valid;
    pie_cmd_t    cmd;
    logic [11:0] acc;
  } pie_req_t;

  // The answer to a transfer, one cycle after the request.
  typedef struct packed {
    logic        done;
    logic        acc_load;
    logic        acc_or;
    logic        skip;
    logic [11:0] data;
  } pie_ans_t;

endpackage

// >>> rtl/pie_divider.sv
`timescale 1ns/1ps
`include "pie_defs.svh"

// Divides a stream of one-cycle ticks by N and emits one tick per N.
module pie_divider #(
  parameter int W = 4,
  parameter int N = 10
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic tick_in,
  output logic      tick_out
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         tick_nxt;

  // Counts input ticks and wraps after the last one of a period.
  always_comb begin
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (tick_in) begin
      if (cnt_r == W'(N - 1)) begin
        cnt_nxt  = '0;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + W'(1);
      end
    end
  end

  // Registers the count and the output tick.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_r    <= '0;
      tick_out <= 1'b0;
    end else begin
      cnt_r    <= cnt_nxt;
      tick_out <= tick_nxt;
    end
  end

endmodule

// >>> rtl/pie_edge_sync.sv
`timescale 1ns/1ps

// Two-stage synchroniser followed by a falling-edge detector.
module pie_edge_sync (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic din,
  output logic      fall
);

  logic meta_r;
  logic sync_r;
  logic last_r;
  logic fall_nxt;

  // A firing is the high-to-low step of the synchronised level.
  always_comb begin
    fall_nxt = last_r & ~sync_r;
  end

  // The first stage feeds only the second stage.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      last_r <= 1'b1;
      fall   <= 1'b0;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
      last_r <= sync_r;
      fall   <= fall_nxt;
    end
  end

endmodule

// >>> rtl/pie_clock_core.sv
`timescale 1ns/1ps
`include "pie_defs.svh"

// Operation
// [RULE_01] Each selected pulse adds one to counter.
// [RULE_02] Pulse at all ones registers an overflow.
// [RULE_03] Counter reaches processor only through buffer.
// [RULE_04] Twelve-bit buffer: loadable, readable, reload or capture.
// [RULE_05] Twelve-bit control word loaded from accumulator.
// [RULE_06] Free run: overflow flag held until cleared.
// [RULE_07] Mode field sits at bits one and two.
// [RULE_08] Mode 00 counts without reload or capture.
// [RULE_09] Mode 01 reloads buffer into counter on overflow.
// [RULE_10] Mode 10 captures counter, counting continues.
// [RULE_11] Mode 11 captures counter, then clears it.
// [RULE_12] Capture happens for any enabled channel.
// [RULE_13] Rate field selects stop, external, or frequency.
// [RULE_14] Overflow sets status only when bit 0 set.
// [RULE_15] Bit 6 enables converter start output.
// [RULE_16] Bit 7 inhibits counting; enabled firing clears it.
// [RULE_17] Bit 8 requests interrupt while status nonzero.
// [RULE_18] Bits 9-11 enable trigger channels 4,2,1.
// [RULE_19] Flag sets regardless of processor interrupt state.
// [RULE_20] Status read ORs bits in, then clears status.
// [RULE_21] Preset transfer loads buffer then counter.
// [RULE_22] Set and clear control bits per accumulator.
// [RULE_23] Counter read copies settled count via buffer.
// [RULE_24] Free run wraps to zero unattended.
// [RULE_25] Inputs synchronised, edge-detected to single pulses.
module pie_clock_core (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire pie_pkg::pie_req_t iot_req,
  input  wire logic             ext_clock_in,
  input  wire logic [2:0]       trig_in,
  output pie_pkg::pie_ans_t     iot_ans,
  output logic                  irq,
  output logic                  clock_flag,
  output logic                  adc_start,
  output logic [11:0]           count_value
);

  // Synchronised falling edges: index 0..2 are triggers 1, 2, 4; index 3 is the external clock.
  logic [3:0] edge_fall;

  // Raw input levels in the same order as the synchronised edges.
  logic [3:0] sync_in;

  // Ticks of the internal time base: 100 kHz, 10 kHz, 1 kHz, 100 Hz.
  logic [3:0] rate_tick;

  // Architectural state.
  logic [11:0] ctrl_r;
  logic [11:0] ctrl_nxt;
  logic [11:0] buf_r;
  logic [11:0] buf_nxt;
  logic [11:0] count_r;
  logic [11:0] count_nxt;
  logic [3:0]  status_r;
  logic [3:0]  status_nxt;
  pie_pkg::pie_ans_t ans_nxt;
  logic        irq_nxt;
  logic        flag_nxt;
  logic        adc_start_nxt;

  // Decoded control fields and per-cycle events.
  pie_pkg::pie_mode_t mode;
  logic [2:0]  rate_sel;
  logic [2:0]  trig_en;
  logic [2:0]  trig_fire;
  logic        any_fire;
  logic        sel_tick;
  logic        count_ok;
  logic        ovf_evt;
  logic        status_clr;
  logic [3:0]  status_set;

  // Gathers the inputs so that every loop index selects a real bit.
  assign sync_in = {ext_clock_in, trig_in};

  // Each input goes through its own synchroniser and edge detector.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      pie_edge_sync u_sync (
        .clk    (clk),
        .resetn (resetn),
        .din    (sync_in[gi]),
        .fall   (edge_fall[gi])  // RULE_25
      );
    end
  endgenerate

  // The fastest rate comes straight from the system clock.
  pie_divider #(
    .W (`PIE_BASE_CYC_W),
    .N (`PIE_BASE_CYC)
  ) u_base (
    .clk      (clk),
    .resetn   (resetn),
    .tick_in  (1'b1),
    .tick_out (rate_tick[0])
  );

  // Each slower rate is a tenth of the one before it.
  generate
    for (gi = 1; gi < 4; gi = gi + 1) begin : g_decade
      pie_divider #(
        .W (`PIE_DECADE_W),
        .N (`PIE_DECADE)
      ) u_dec (
        .clk      (clk),
        .resetn   (resetn),
        .tick_in  (rate_tick[gi-1]),
        .tick_out (rate_tick[gi])
      );
    end
  endgenerate

  // Field decode of the control word.
  always_comb begin
    mode      = pie_pkg::pie_mode_t'(ctrl_r[`PIE_MODE_HI:`PIE_MODE_LO]);  // RULE_07
    rate_sel  = ctrl_r[`PIE_RATE_HI:`PIE_RATE_LO];
    trig_en   = {ctrl_r[`PIE_TRIG4_EN], ctrl_r[`PIE_TRIG2_EN], ctrl_r[`PIE_TRIG1_EN]};  // RULE_18
    trig_fire = edge_fall[2:0] & trig_en;
    any_fire  = |trig_fire;
  end

  // Rate selection; codes 000 and 111 stop the counter, code 110 runs at 1 kHz.
  always_comb begin
    unique case (rate_sel)
      3'h1:    sel_tick = edge_fall[3];  // RULE_13
      3'h2:    sel_tick = rate_tick[3];
      3'h3:    sel_tick = rate_tick[2];
      3'h4:    sel_tick = rate_tick[1];
      3'h5:    sel_tick = rate_tick[0];
      3'h6:    sel_tick = rate_tick[2];
      default: sel_tick = 1'b0;
    endcase
  end

  // Counter, buffer, control and status next values, processor transfers last so they win over all but a new status event.
  always_comb begin
    ctrl_nxt   = ctrl_r;
    buf_nxt    = buf_r;
    count_nxt  = count_r;
    status_clr = 1'b0;
    status_set = 4'h0;
    ovf_evt    = 1'b0;
    ans_nxt    = '0;

    // Counting is held off while the inhibit bit is set.
    count_ok = sel_tick & ~ctrl_r[`PIE_INHIBIT];  // RULE_16

    // One step per selected pulse; the step past all ones is an overflow.
    if (count_ok) begin
      if (count_r == `PIE_ALL_ONES) begin
        ovf_evt = 1'b1;  // RULE_02
        if (mode == pie_pkg::PIE_MODE_RELOAD) begin  // RULE_08
          count_nxt = buf_r;  // RULE_09
        end else begin
          count_nxt = 12'h000;  // RULE_24
        end
      end else begin
        count_nxt = count_r + 12'h001;  // RULE_01
      end
    end

    // In the capture modes any enabled channel copies the count into the buffer.
    if (mode[1] && any_fire) begin  // RULE_12
      buf_nxt = count_r;  // RULE_10
      if (mode == pie_pkg::PIE_MODE_CAP_CLR) begin
        count_nxt = 12'h000;  // RULE_11
      end
    end

    // An enabled firing releases the inhibit.
    if (any_fire) begin
      ctrl_nxt[`PIE_INHIBIT] = 1'b0;  // RULE_16
    end

    // Status collects overflow only when enabled, and enabled channel firings.
    status_set[3]   = ovf_evt & ctrl_r[`PIE_EN_OVF];  // RULE_14
    status_set[2:0] = trig_fire;  // RULE_18

    // Processor transfers.
    if (iot_req.valid) begin
      ans_nxt.done = 1'b1;
      unique case (iot_req.cmd)
        pie_pkg::PIE_CMD_CLR_BITS: begin
          ctrl_nxt = ctrl_nxt & ~iot_req.acc;  // RULE_22
        end
        pie_pkg::PIE_CMD_SET_BITS: begin
          ctrl_nxt = ctrl_nxt | iot_req.acc;  // RULE_22
        end
        pie_pkg::PIE_CMD_SKIP: begin
          ans_nxt.skip = |status_r;
        end
        pie_pkg::PIE_CMD_PRESET: begin
          buf_nxt   = iot_req.acc;  // RULE_21
          count_nxt = iot_req.acc;
        end
        pie_pkg::PIE_CMD_RD_CTRL: begin
          ans_nxt.acc_load = 1'b1;
          ans_nxt.data     = ctrl_r;
        end
        pie_pkg::PIE_CMD_RD_STATUS: begin
          ans_nxt.acc_or              = 1'b1;  // RULE_20
          ans_nxt.data[`PIE_ST_OVF]   = status_r[3];
          ans_nxt.data[`PIE_ST_EV4]   = status_r[2];
          ans_nxt.data[`PIE_ST_EV2]   = status_r[1];
          ans_nxt.data[`PIE_ST_EV1]   = status_r[0];
          status_clr                  = 1'b1;
        end
        pie_pkg::PIE_CMD_RD_BUF: begin
          ans_nxt.acc_load = 1'b1;  // RULE_04
          ans_nxt.data     = buf_r;
        end
        pie_pkg::PIE_CMD_RD_COUNT: begin
          // The value after this cycle's step is taken, never a count in transition.
          buf_nxt          = count_nxt;  // RULE_23
          ans_nxt.acc_load = 1'b1;  // RULE_03
          ans_nxt.data     = count_nxt;
        end
      endcase
    end

    // A new event in the clearing cycle survives the clear.
    status_nxt = (status_r & ~{4{status_clr}}) | status_set;  // RULE_06

    // Flag follows status whatever the processor interrupt state; the interrupt also needs control bit 8 set.
    flag_nxt = |status_nxt;  // RULE_19
    irq_nxt  = ctrl_nxt[`PIE_IRQ_EN] & (|status_nxt);  // RULE_17

    // The converter start pulse accompanies each overflow when enabled.
    adc_start_nxt = ovf_evt & ctrl_r[`PIE_EXT_START];  // RULE_15
  end

  // Registers all state; every output except count_value comes from here.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl_r     <= `PIE_CTRL_RST;
      buf_r      <= `PIE_BUF_RST;
      count_r    <= `PIE_COUNT_RST;
      status_r   <= 4'h0;
      iot_ans    <= '0;
      irq        <= 1'b0;
      clock_flag <= 1'b0;
      adc_start  <= 1'b0;
    end else begin
      ctrl_r     <= ctrl_nxt;  // RULE_05
      buf_r      <= buf_nxt;
      count_r    <= count_nxt;
      status_r   <= status_nxt;
      iot_ans    <= ans_nxt;
      irq        <= irq_nxt;
      clock_flag <= flag_nxt;
      adc_start  <= adc_start_nxt;
    end
  end

  // Mirror of the counter for observation only.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      count_value <= `PIE_COUNT_RST;
    end else begin
      count_value <= count_nxt;
    end
  end

endmodule

// >>> tb/pie_clock_core_props.sv
`timescale 1ns/1ps

// Checks answer timing and register effects at the core's ports.
module pie_clock_core_props (
  input wire logic              clk,
  input wire logic              resetn,
  input wire pie_pkg::pie_req_t iot_req,
  input wire logic              ext_clock_in,
  input wire logic [2:0]        trig_in,
  input wire pie_pkg::pie_ans_t iot_ans,
  input wire logic              irq,
  input wire logic              clock_flag,
  input wire logic              adc_start,
  input wire logic [11:0]       count_value
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  logic [7:0] take;
  // One strobe per command code taken at this edge.
  always_comb begin
    take = '0;
    if (iot_req.valid) take[iot_req.cmd] = 1'b1;
  end
  a_ans_timing: assert property (
    iot_ans.done == $past(iot_req.valid)) else $error("answer timing wrong");
  a_snap_to_acc: assert property (
    take[7] |=> iot_ans.acc_load && iot_ans.data == count_value) else $error("counter read wrong");
  a_status_or: assert property (
    take[5] |=> iot_ans.acc_or && !iot_ans.acc_load) else $error("status read not ORed");
  a_acc_kept: assert property (
    take[0] || take[2] || take[3] |=> !iot_ans.acc_load && !iot_ans.acc_or) else $error("acc touched");
  a_buf_read: assert property (
    take[6] |=> iot_ans.acc_load && !iot_ans.acc_or) else $error("buffer read wrong");
  a_irq_flag: assert property (
    irq |-> clock_flag) else $error("irq without flag");
  a_set_bits: assert property (
    take[2] ##1 take[4] |=> (iot_ans.data & $past(iot_req.acc, 2) & 12'hfef) ==
    ($past(iot_req.acc, 2) & 12'hfef)) else $error("set bits lost");
  a_clr_bits: assert property (
    take[0] ##1 take[4] |=> (iot_ans.data & $past(iot_req.acc, 2)) == 12'h000) else $error("clear bits kept");
  a_preset_cnt: assert property (
    take[3] ##1 !take[3] |=> count_value == $past(iot_req.acc, 2) ||
    count_value == $past(iot_req.acc, 2) + 12'h001) else $error("preset not in counter");
  a_ovf_adc: assert property (
    adc_start |-> $past(count_value) == 12'hfff || $past(count_value, 2) == 12'hfff)
    else $error("start without overflow");
  c_status: cover property (take[5] ##1 iot_ans.data[11]);
  c_adc: cover property (adc_start);
  c_irq: cover property (irq);
endmodule

bind pie_clock_core pie_clock_core_props u_props (.clk(clk), .resetn(resetn), .iot_req(iot_req),
  .ext_clock_in(ext_clock_in), .trig_in(trig_in), .iot_ans(iot_ans), .irq(irq), .clock_flag(clock_flag),
  .adc_start(adc_start), .count_value(count_value));

// >>> tb/pie_cpu_model.sv
`timescale 1ns/1ps

// Processor side: one transfer at a time, answer applied to its accumulator.
module pie_cpu_model (
  input  wire logic              clk,
  output pie_pkg::pie_req_t      iot_req,
  input  wire pie_pkg::pie_ans_t iot_ans
);
  // Bus idle until the first transfer.
  initial begin
    iot_req = '0;
  end
  // Hold keeps valid up so the next transfer follows at the very next edge.
  task automatic xfer(input logic [2:0] c, input logic [11:0] a, input bit hold, output logic [11:0] res);
    int n;
    res = a;
    if (iot_req.valid !== 1'b1) @(negedge clk);
    iot_req = {1'b1, pie_pkg::pie_cmd_t'(c), a};
    @(negedge clk);
    if (!hold) iot_req = {1'b0, pie_pkg::pie_cmd_t'(~c), ~a};
    for (n = 0; n < 2 && iot_ans.done !== 1'b1; n++) @(negedge clk);
    if (iot_ans.acc_load === 1'b1) res = iot_ans.data;
    else if (iot_ans.acc_or === 1'b1) res = a | iot_ans.data;
  endtask
endmodule

// >>> tb/programmable_interval_event_clock_tb.sv
`timescale 1ns/1ps

// Self-checking bench with a processor model on the transfer port.
module programmable_interval_event_clock_tb;
  logic              clk;
  logic              resetn;
  logic              ext_clock_in;
  logic [2:0]        trig_in;
  pie_pkg::pie_req_t iot_req;
  pie_pkg::pie_ans_t iot_ans;
  logic              irq;
  logic              clock_flag;
  logic              adc_start;
  logic [11:0]       count_value;
  logic [11:0]       r;
  logic [11:0]       q;
  logic [11:0]       v;
  int                fails = 0;
  int                checked = 0;
  int                cyc = 0;
  int                m;
  int                c;
  int                adc_cnt = 0;

  pie_clock_core u_pie_clock_core (.clk(clk), .resetn(resetn), .iot_req(iot_req), .ext_clock_in(ext_clock_in),
    .trig_in(trig_in), .iot_ans(iot_ans), .irq(irq), .clock_flag(clock_flag), .adc_start(adc_start),
    .count_value(count_value));
  pie_cpu_model u_pie_cpu_model (.clk(clk), .iot_req(iot_req), .iot_ans(iot_ans));

  // Free-running 125 MHz clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Cuts a hung run short.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fails++;
      give_verdict();
    end
  end

  // Counts converter start pulses seen on the output.
  always @(posedge clk) begin
    if (adc_start === 1'b1) adc_cnt <= adc_cnt + 1;
  end

  task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic io(input logic [2:0] cm, input logic [11:0] a, input bit h = 0);
    u_pie_cpu_model.xfer(cm, a, h, v);
  endtask

  // Channel 3 is the external count input; the others are trigger channels.
  task automatic pulse(input int ch, input int n);
    repeat (n) begin
      @(negedge clk);
      if (ch == 3) ext_clock_in = 1'b0;
      else trig_in[ch] = 1'b0;
      repeat (3) @(negedge clk);
      ext_clock_in = 1'b1;
      trig_in = 3'b111;
      repeat (3) @(negedge clk);
    end
    repeat (8) @(negedge clk);
  endtask

  // Control word from mode, rate and the six low control bits.
  function automatic logic [11:0] ctl(input logic [1:0] md, input logic [2:0] rt, input logic [5:0] lo);
    return {1'b0, md, rt, lo};
  endfunction

  task automatic setctl(input logic [11:0] a);
    io(0, 12'hfff, 1);
    io(2, a);
  endtask

  task automatic give_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Main sequence.
  initial begin
    resetn = 1'b0;
    ext_clock_in = 1'b1;
    trig_in = 3'b111;
    void'($urandom(20));
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    io(4, 12'h000);
    chk("ctrl", v, 12'h000);
    io(6, 12'h000);
    chk("buf", v, 12'h000);
    $display("test 1 done");
    repeat (4) begin
      r = 12'($urandom);
      q = 12'($urandom);
      setctl(q & 12'hfef);
      io(2, r, 1);
      io(4, 12'h000);
      chk("set", v, (q & 12'hfef) | r);
      io(0, q, 1);
      io(4, 12'h000);
      chk("clr", v, r & ~q);
    end
    $display("test 2 done");
    setctl(12'h000);
    r = 12'($urandom);
    io(3, r);
    chk("acc", v, r);
    io(6, 12'h000);
    chk("buf", v, r);
    io(7, 12'h000);
    chk("count", v, r);
    $display("test 3 done");
    setctl(12'h800 | ctl(2'h0, 3'h1, 6'h28));
    io(3, 12'hffd);
    pulse(3, 3);
    io(7, 12'h000);
    chk("wrap", v, 12'h000);
    chk("irq", {11'h000, irq}, 12'h001);
    chk("flag", {11'h000, clock_flag}, 12'h001);
    io(1, 12'h000);
    chk("skip", {11'h000, iot_ans.skip}, 12'h001);
    chk("adc", 12'(adc_cnt), 12'h001);
    io(5, 12'h000);
    chk("status", v, 12'h800);
    repeat (2) @(negedge clk);
    chk("flag", {11'h000, clock_flag}, 12'h000);
    io(1, 12'h000);
    chk("skip", {11'h000, iot_ans.skip}, 12'h000);
    $display("test 4 done");
    setctl(ctl(2'h0, 3'h1, 6'h11));
    io(3, 12'h010);
    pulse(3, 2);
    io(7, 12'h000);
    chk("inhibit", v, 12'h010);
    pulse(0, 1);
    io(4, 12'h000);
    chk("ctrl", v, ctl(2'h0, 3'h1, 6'h01));
    io(5, 12'h000);
    chk("event", v, 12'h001);
    pulse(3, 1);
    io(7, 12'h000);
    chk("count", v, 12'h011);
    $display("test 5 done");
    setctl(ctl(2'h1, 3'h1, 6'h00));
    io(3, 12'hffe);
    pulse(3, 2);
    io(7, 12'h000);
    chk("reload", v, 12'hffe);
    io(5, 12'h000);
    chk("status", v, 12'h000);
    chk("adc", 12'(adc_cnt), 12'h001);
    $display("test 6 done");
    for (m = 2; m < 4; m++) begin
      setctl(ctl(2'(m), 3'h1, 6'h07));
      r = 12'($urandom);
      c = $urandom_range(2, 0);
      io(3, r);
      pulse(c, 1);
      io(6, 12'h000);
      chk("capture", v, r);
      io(7, 12'h000);
      chk("after", v, (m == 3) ? 12'h000 : r);
      io(5, 12'h000);
      chk("event", v, 12'h001 << c);
    end
    $display("test 7 done");
    // Internal 100 kHz rate: align on the first step, then one period gives one more.
    setctl(ctl(2'h0, 3'h5, 6'h00));
    io(3, 12'h000);
    for (m = 0; m < 1400 && count_value == 12'h000; m++) @(negedge clk);
    repeat (1250) @(negedge clk);
    io(7, 12'h000);
    chk("rate", v, 12'h002);
    $display("test 8 done");
    give_verdict();
  end
endmodule
